// >>> include/uart_pkg.sv
// Constants, register map and carrier types for the host-bus serial controller
package uart_pkg;
  localparam logic [2:0] REG_DATA   = 3'h0;  // Receive buffer / transmit holding
  localparam logic [2:0] REG_IEN    = 3'h1;  // Interrupt enable
  localparam logic [2:0] REG_IID    = 3'h2;  // Interrupt identification
  localparam logic [2:0] REG_LCTL   = 3'h3;  // line_control_reg
  localparam logic [2:0] REG_MCTL   = 3'h4;  // Modem control
  localparam logic [2:0] REG_LSTAT  = 3'h5;  // line_status_reg
  localparam logic [2:0] REG_MSTAT  = 3'h6;  // Modem status
  localparam logic [2:0] REG_SCR    = 3'h7;  // Scratch
  // line_control_reg fields
  localparam int LC_WLEN = 0;  // Two bits: length minus five
  localparam int LC_STOP = 2;
  localparam int LC_PEN  = 3;
  localparam int LC_EPS  = 4;
  localparam int LC_BRK  = 6;
  localparam int LC_DLAB = 7;
  // Modem control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  // Interrupt enable fields
  localparam int IE_RX  = 0;
  localparam int IE_TX  = 1;
  localparam int IE_LS  = 2;
  localparam int IE_MS  = 3;
  localparam logic [7:0]  LCTL_RESET = 8'h00;
  localparam logic [7:0]  MCTL_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET  = 16'h0001;
  localparam int          OVERSAMPLE = 16;
  localparam int          CLK_HZ     = 100_000_000;
  localparam int          MAX_BAUD   = 56_000;
  // Smallest divisor that keeps the baud clock at or below sixteen times the top rate
  localparam logic [15:0] DIV_MIN    = 16'((CLK_HZ + OVERSAMPLE * MAX_BAUD - 1)
                                           / (OVERSAMPLE * MAX_BAUD));
  localparam logic [3:0]  HALF_BIT   = 4'h7;
  localparam logic [3:0]  LAST_TICK  = 4'hF;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic       sel;
  } bus_sel_t;

  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
    logic       brk;
  } rx_word_t;
endpackage

// >>> rtl/uart_core.sv
// Serial controller with host bus interface, baud generator, line logic and receive FIFO
module uart_core
  import uart_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic       i_clk,            // master_clock_in
  input  wire logic       i_rst_n,          // Sync reset, active low
  input  wire logic       i_master_reset,   // Active high master reset
  output logic            o_inv_clk,        // inverted_clock_out
  input  wire logic [2:0] i_register_select,// Register select
  input  wire logic [2:0] i_chip_select,    // [0],[1] high-true, [2] low-true
  input  wire logic       i_address_strobe, // Latch on rise; tie low if unused
  input  wire logic       i_rd,             // Read strobe, active high
  input  wire logic       i_rd_n,           // Read strobe, active low
  input  wire logic       i_wr,             // Write strobe, active high
  input  wire logic       i_wr_n,           // Write strobe, active low
  input  wire logic [7:0] i_data,           // host_data_bus in
  output logic [7:0]      o_data,           // host_data_bus out
  output logic            o_data_oe,        // High while driving data bus
  output logic            o_bus_driver_disable, // Low while driving read data
  output logic            o_selected,       // selected_indicator
  output logic            o_sout,           // Serial out
  input  wire logic       i_sin,            // Serial in
  input  wire logic       i_rclk,           // Receive 16x tick, sampled
  output logic            o_baud_clock_out, // 16x baud tick
  output logic            o_rts_n,          // Request to send, active low
  output logic            o_dtr_n,          // Data terminal ready, active low
  output logic            o_out1_n,         // General output 1
  output logic            o_out2_n,         // General output 2
  input  wire logic       i_cts_n,          // Clear to send
  input  wire logic       i_dsr_n,          // Data set ready
  input  wire logic       i_dcd_n,          // Carrier detect
  input  wire logic       i_ri_n,           // Ring indicator
  output logic            o_interrupt_out,  // Active high interrupt
  output logic            o_rx_fifo_full    // Receive buffer full; further characters are dropped and set overrun
);
  typedef struct packed {
    bus_sel_t   lat;
    logic       ads_d;
    logic       rd_d;
    logic       wr_d;
    logic [7:0] rdata;
    logic       read_act;
    logic [7:0] ien;
    logic [7:0] lctl;
    logic [7:0] mctl;
    logic [7:0] scr;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic       btick;
    logic [7:0] thr;
    logic       thr_full;
    logic [7:0] tsr;
    tx_state_t  tst;
    logic [3:0] ttk;
    logic [2:0] tbit;
    logic       tpar;
    logic       tline;
    logic       tx_int;
    logic       rclk_d;
    logic       sin_d;
    rx_state_t  rst;
    logic [3:0] rtk;
    logic [2:0] rbit;
    logic [7:0] rsr;
    logic       rpar;
    logic       rallz;
    logic       overrun;
    logic       perr;
    logic       ferr;
    logic       brk;
    logic [3:0] msd;
    logic [3:0] mprev;
  } core_state_t;
  core_state_t s_reg, s_next;

  logic       rst_all, rd_act, wr_act, sel_now, ads_low;
  bus_sel_t   sel_cur;
  logic       rd_pulse, wr_pulse, rx_tick, sin_eff;
  logic [2:0] nbits;
  logic [10:0] rxf_in, rxf_out;
  logic       rxf_push, rxf_ready, rxf_valid, rxf_pop;
  logic [7:0] lstat, iid;
  logic [3:0] mlive;
  logic       ls_int;

  assign rst_all = !i_rst_n || i_master_reset;
  assign o_inv_clk = ~i_clk;
  assign rd_act = i_rd | ~i_rd_n;
  assign wr_act = i_wr | ~i_wr_n;
  assign sel_now = i_chip_select[0] & i_chip_select[1] & ~i_chip_select[2];
  // Strobe held low means the latch is transparent
  assign ads_low = ~i_address_strobe;
  assign sel_cur = ads_low ? bus_sel_t'{addr: i_register_select, sel: sel_now} : s_reg.lat;
  assign o_selected = sel_cur.sel;
  assign rd_pulse = rd_act & ~s_reg.rd_d & sel_cur.sel;
  assign wr_pulse = wr_act & ~s_reg.wr_d & sel_cur.sel;
  assign o_data_oe = s_reg.read_act;
  assign o_bus_driver_disable = ~s_reg.read_act;
  assign o_data = s_reg.rdata;
  assign o_baud_clock_out = s_reg.btick;
  assign rx_tick = i_rclk & ~s_reg.rclk_d;
  assign sin_eff = s_reg.mctl[MC_LOOP] ? s_reg.tline : i_sin;
  assign o_sout = s_reg.mctl[MC_LOOP] ? 1'b1 : (s_reg.tline & ~s_reg.lctl[LC_BRK]);
  // In loopback the modem outputs go inactive and feed the status bits instead
  assign o_rts_n  = s_reg.mctl[MC_LOOP] | ~s_reg.mctl[MC_RTS];
  assign o_dtr_n  = s_reg.mctl[MC_LOOP] | ~s_reg.mctl[MC_DTR];
  assign o_out1_n = s_reg.mctl[MC_LOOP] | ~s_reg.mctl[MC_OUT1];
  assign o_out2_n = s_reg.mctl[MC_LOOP] | ~s_reg.mctl[MC_OUT2];
  assign mlive = s_reg.mctl[MC_LOOP] ? s_reg.mctl[3:0] : {~i_dcd_n, ~i_ri_n, ~i_dsr_n, ~i_cts_n};
  assign nbits = 3'(s_reg.lctl[LC_WLEN +: 2]) + 3'h4;
  assign rxf_pop = rd_pulse && sel_cur.addr == REG_DATA && !s_reg.lctl[LC_DLAB];
  assign o_rx_fifo_full = ~rxf_ready;
  assign lstat = {1'b0, (s_reg.tst == TX_IDLE) & ~s_reg.thr_full, ~s_reg.thr_full,
                  s_reg.brk, s_reg.ferr, s_reg.perr, s_reg.overrun, rxf_valid};
  assign ls_int = s_reg.ien[IE_LS] & (s_reg.overrun | s_reg.perr | s_reg.ferr | s_reg.brk);
  always_comb begin
    if (ls_int) begin
      iid = 8'h06;
    end else if (s_reg.ien[IE_RX] & rxf_valid) begin
      iid = 8'h04;
    end else if (s_reg.ien[IE_TX] & s_reg.tx_int) begin
      iid = 8'h02;
    end else if (s_reg.ien[IE_MS] & (s_reg.msd != 4'h0)) begin
      iid = 8'h00;
    end else begin
      iid = 8'h01;
    end
  end
  assign o_interrupt_out = ~iid[0] & s_reg.mctl[MC_OUT2];

  uart_fifo #(.W(11), .D(FIFO_DEPTH)) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst_n (~rst_all),
    .i_data  (rxf_in),
    .i_valid (rxf_push),
    .o_ready (rxf_ready),
    .o_data  (rxf_out),
    .o_valid (rxf_valid),
    .i_ready (rxf_pop),
    .o_full  ()
  );

  always_comb begin
    s_next = s_reg;
    rxf_push = 1'b0;
    rxf_in = {s_reg.rsr, 3'h0};
    s_next.rd_d = rd_act;
    s_next.wr_d = wr_act;
    s_next.ads_d = i_address_strobe;
    s_next.rclk_d = i_rclk;
    s_next.sin_d = sin_eff;
    if (i_address_strobe & ~s_reg.ads_d) begin
      s_next.lat = '{addr: i_register_select, sel: sel_now};
    end
    s_next.read_act = sel_cur.sel & rd_act;
    s_next.msd = s_reg.msd | (mlive ^ s_reg.mprev);
    s_next.mprev = mlive;
    // Baud divider
    s_next.btick = 1'b0;
    if (s_reg.bcnt >= s_reg.div - 16'h1) begin
      s_next.bcnt = 16'h0;
      s_next.btick = 1'b1;
    end else begin
      s_next.bcnt = s_reg.bcnt + 16'h1;
    end
    // Register reads
    if (rd_pulse) begin
      unique case (sel_cur.addr)
        REG_DATA:  s_next.rdata = s_reg.lctl[LC_DLAB] ? s_reg.div[7:0] : rxf_out[10:3];
        REG_IEN:   s_next.rdata = s_reg.lctl[LC_DLAB] ? s_reg.div[15:8] : s_reg.ien;
        REG_IID:   s_next.rdata = iid;
        REG_LCTL:  s_next.rdata = s_reg.lctl;
        REG_MCTL:  s_next.rdata = s_reg.mctl;
        REG_LSTAT: s_next.rdata = lstat;
        REG_MSTAT: s_next.rdata = {mlive, s_reg.msd};
        REG_SCR:   s_next.rdata = s_reg.scr;
      endcase
      if (sel_cur.addr == REG_LSTAT) begin
        // Set wins: an error arriving this cycle is merged below
        s_next.overrun = 1'b0;
        s_next.perr = 1'b0;
        s_next.ferr = 1'b0;
        s_next.brk = 1'b0;
      end
      if (sel_cur.addr == REG_MSTAT) begin
        s_next.msd = mlive ^ s_reg.mprev;
      end
      if (sel_cur.addr == REG_IID && iid == 8'h02) begin
        s_next.tx_int = 1'b0;
      end
    end
    // Register writes
    if (wr_pulse) begin
      unique case (sel_cur.addr)
        REG_DATA: begin
          if (s_reg.lctl[LC_DLAB]) begin
            s_next.div[7:0] = i_data;
          end else begin
            s_next.thr = i_data;
            s_next.thr_full = 1'b1;
            s_next.tx_int = 1'b0;
          end
        end
        REG_IEN: begin
          if (s_reg.lctl[LC_DLAB]) begin
            s_next.div[15:8] = i_data;
          end else begin
            s_next.ien = {4'h0, i_data[3:0]};
          end
        end
        REG_IID:   s_next.scr = s_reg.scr;
        REG_LCTL:  s_next.lctl = i_data;
        REG_MCTL:  s_next.mctl = {3'h0, i_data[4:0]};
        REG_LSTAT: s_next.scr = s_reg.scr;
        REG_MSTAT: s_next.scr = s_reg.scr;
        REG_SCR:   s_next.scr = i_data;
      endcase
    end
    if (s_next.div < DIV_MIN) begin
      s_next.div = DIV_MIN;
    end
    // Transmitter, one bit per sixteen baud ticks
    if (s_reg.btick) begin
      s_next.ttk = s_reg.ttk + 4'h1;
      unique case (s_reg.tst)
        TX_IDLE: begin
          s_next.ttk = 4'h0;
          s_next.tline = 1'b1;
          if (s_reg.thr_full) begin
            s_next.tsr = s_reg.thr;
            // A host write landing in the load cycle keeps the holding register full
            s_next.thr_full = wr_pulse && (sel_cur.addr == REG_DATA) && !s_reg.lctl[LC_DLAB];
            s_next.tx_int = ~s_next.thr_full;
            s_next.tpar = ~s_reg.lctl[LC_EPS];
            s_next.tline = 1'b0;
            s_next.tst = TX_START;
          end
        end
        TX_START: begin
          if (s_reg.ttk == LAST_TICK) begin
            s_next.tline = s_reg.tsr[0];
            s_next.tpar = s_reg.tpar ^ s_reg.tsr[0];
            s_next.tbit = 3'h0;
            s_next.tst = TX_DATA;
          end
        end
        TX_DATA: begin
          if (s_reg.ttk == LAST_TICK) begin
            s_next.tsr = {1'b0, s_reg.tsr[7:1]};
            s_next.tbit = s_reg.tbit + 3'h1;
            if (s_reg.tbit == nbits) begin
              // Cleared so the second stop bit is counted for every length
              s_next.tbit = 3'h0;
              s_next.tline = s_reg.lctl[LC_PEN] ? s_reg.tpar : 1'b1;
              s_next.tst = s_reg.lctl[LC_PEN] ? TX_PAR : TX_STOP;
            end else begin
              s_next.tline = s_reg.tsr[1];
              s_next.tpar = s_reg.tpar ^ s_reg.tsr[1];
            end
          end
        end
        TX_PAR: begin
          if (s_reg.ttk == LAST_TICK) begin
            s_next.tline = 1'b1;
            s_next.tst = TX_STOP;
          end
        end
        TX_STOP: begin
          s_next.tline = 1'b1;
          // Second stop bit counted through tbit reuse
          if (s_reg.ttk == LAST_TICK) begin
            if (s_reg.lctl[LC_STOP] && s_reg.tbit != 3'h7) begin
              s_next.tbit = 3'h7;
            end else begin
              s_next.tst = TX_IDLE;
            end
          end
        end
      endcase
    end
    // Receiver on the 16x receive tick
    if (rx_tick) begin
      s_next.rtk = s_reg.rtk + 4'h1;
      unique case (s_reg.rst)
        RX_IDLE: begin
          s_next.rtk = 4'h0;
          if (!s_reg.sin_d) begin
            s_next.rst = RX_START;
          end
        end
        RX_START: begin
          if (s_reg.rtk == HALF_BIT) begin
            s_next.rtk = 4'h0;
            s_next.rst = s_reg.sin_d ? RX_IDLE : RX_DATA;
            s_next.rbit = 3'h0;
            s_next.rsr = 8'h00;
            s_next.rpar = ~s_reg.lctl[LC_EPS];
            s_next.rallz = 1'b1;
          end
        end
        RX_DATA: begin
          if (s_reg.rtk == LAST_TICK) begin
            s_next.rsr[s_reg.rbit] = s_reg.sin_d;
            s_next.rpar = s_reg.rpar ^ s_reg.sin_d;
            s_next.rallz = s_reg.rallz & ~s_reg.sin_d;
            s_next.rbit = s_reg.rbit + 3'h1;
            if (s_reg.rbit == nbits) begin
              s_next.rst = s_reg.lctl[LC_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (s_reg.rtk == LAST_TICK) begin
            s_next.rpar = s_reg.rpar ^ s_reg.sin_d;
            s_next.rallz = s_reg.rallz & ~s_reg.sin_d;
            s_next.rst = RX_STOP;
          end
        end
        RX_STOP: begin
          if (s_reg.rtk == LAST_TICK) begin
            s_next.rst = RX_IDLE;
            if (rxf_ready) begin
              rxf_push = 1'b1;
              rxf_in = {s_reg.rsr, s_reg.lctl[LC_PEN] & s_reg.rpar, ~s_reg.sin_d,
                        s_reg.rallz & ~s_reg.sin_d};
            end else begin
              s_next.overrun = 1'b1;
            end
            s_next.ferr = ~s_reg.sin_d;
            s_next.perr = s_reg.lctl[LC_PEN] & s_reg.rpar;
            s_next.brk = s_reg.rallz & ~s_reg.sin_d;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      s_reg <= '0;
      s_reg.lctl <= LCTL_RESET;
      s_reg.mctl <= MCTL_RESET;
      s_reg.div <= DIV_RESET;
      s_reg.tline <= 1'b1;
      s_reg.sin_d <= 1'b1;
      s_reg.tst <= TX_IDLE;
      s_reg.rst <= RX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  sel_follows_a: assert property (@(posedge i_clk) disable iff (rst_all)
    ads_low |-> (o_selected == sel_now)) else $error("select not transparent");
  cs_decode_a: assert property (@(posedge i_clk) disable iff (rst_all)
    (ads_low && i_chip_select != 3'b011) |-> !o_selected) else $error("bad decode");
  bus_drive_a: assert property (@(posedge i_clk) disable iff (rst_all)
    o_data_oe |-> ($past(sel_cur.sel) && $past(rd_act))) else $error("bus driven idle");
  bus_driver_disable_pair_a: assert property (@(posedge i_clk) disable iff (rst_all)
    o_bus_driver_disable != o_data_oe) else $error("driver disable mismatch");
  rts_ctl_a: assert property (@(posedge i_clk) disable iff (rst_all)
    (s_reg.mctl[MC_RTS] && !s_reg.mctl[MC_LOOP]) |-> !o_rts_n) else $error("rts wrong");
  one_access_a: assert property (@(posedge i_clk) disable iff (rst_all)
    rd_pulse |=> !rd_pulse) else $error("double read");
  wr_store_a: assert property (@(posedge i_clk) disable iff (rst_all)
    (wr_pulse && sel_cur.addr == REG_SCR) |=> (s_reg.scr == $past(i_data)))
    else $error("scratch write lost");
  loop_quiet_a: assert property (@(posedge i_clk) disable iff (rst_all)
    s_reg.mctl[MC_LOOP] |-> o_sout) else $error("sout active in loopback");
  break_out_a: assert property (@(posedge i_clk) disable iff (rst_all)
    (s_reg.lctl[LC_BRK] && !s_reg.mctl[MC_LOOP]) |-> !o_sout) else $error("no break");
endmodule

// >>> rtl/uart_fifo.sv
// Flip-flop FIFO with valid/ready handshakes on both sides
module uart_fifo
  import uart_pkg::*;
#(
  parameter int W = 11,
  parameter int D = 32
) (
  input  wire logic         i_clk,     // Clock
  input  wire logic         i_rst_n,   // Sync reset, active low
  input  wire logic [W-1:0] i_data,    // Write data
  input  wire logic         i_valid,   // Write request
  output logic              o_ready,   // Not full
  output logic [W-1:0]      o_data,    // Head word
  output logic              o_valid,   // Not empty
  input  wire logic         i_ready,   // Pop
  output logic              o_full     // Full flag
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_state_t;
  fifo_state_t st_reg, st_next;
  logic push, pop;
  assign o_ready = (st_reg.cnt != (AW+1)'(D));
  assign o_valid = (st_reg.cnt != '0);
  assign o_full  = ~o_ready;
  assign o_data  = st_reg.mem[st_reg.rp];
  assign push    = i_valid & o_ready;
  assign pop     = i_ready & o_valid;
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = i_data;
      st_next.wp = (st_reg.wp == AW'(D-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(D-1)) ? '0 : st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// >>> verif/serial_peer.sv
// Far-end serial equipment: sends and receives asynchronous frames
module serial_peer
  import uart_pkg::*;
#(
  parameter int BIT = 1792
) (
  input  wire logic i_clk,   // Clock
  input  wire logic i_sout,  // Device serial out
  output logic      o_sin,   // Device serial in
  output logic      o_mdm_n  // Modem status lines, held inactive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sin   = 1'b1;
    o_mdm_n = 1'b1;
  end
  // Line idles at mark between frames, as a real modem leaves it
  task automatic hold_bit(input logic v);
    o_sin = v;
    repeat (BIT) @(negedge i_clk);
  endtask
  task automatic send(input logic [7:0] d, input int n, input logic pen, even, stop);
    logic [7:0] m;
    m = d & 8'((1 << n) - 1);
    @(negedge i_clk);
    hold_bit(1'b0);
    for (int i = 0; i < n; i++) hold_bit(m[i]);
    if (pen) hold_bit(even ? ^m : ~^m);
    hold_bit(stop);
    o_sin = 1'b1;
  endtask
  // Samples at bit centres; ok reports a clean start and stop
  task automatic recv(input int n, input logic pen, output logic [7:0] d, output logic p,
                      output logic ok);
    int w;
    d = 8'h00;
    p = 1'b0;
    w = 0;
    while (i_sout !== 1'b0 && w < 4000) begin
      @(negedge i_clk);
      w++;
    end
    repeat (BIT / 2) @(negedge i_clk);
    ok = (i_sout === 1'b0) && (w < 4000);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(negedge i_clk);
      d[i] = i_sout;
    end
    if (pen) begin
      repeat (BIT) @(negedge i_clk);
      p = i_sout;
    end
    repeat (BIT) @(negedge i_clk);
    ok = ok && (i_sout === 1'b1);
  endtask
endmodule

// >>> verif/tb_uart_core.sv
// Self-checking bench for the host-bus serial controller
module tb_uart_core;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_pkg::*;
  logic       clk = 1'b0, rst_n, mrst, address_strobe, rd, rd_n, wr, wr_n, oe, bus_driver_disable, sel, inv_clk;
  logic       sout, sin, baud, rts_n, mdm_n, irq, oe_seen, p, ok;
  logic [2:0] rsel, cs, mo_n;
  logic [7:0] din, dout, d;
  int         failures = 0, total_checks = 0, cycles = 0, n;

  uart_core uart_core_inst (.i_clk(clk), .i_rst_n(rst_n), .i_master_reset(mrst),
    .o_inv_clk(inv_clk), .i_register_select(rsel), .i_chip_select(cs),
    .i_address_strobe(address_strobe), .i_rd(rd), .i_rd_n(rd_n), .i_wr(wr), .i_wr_n(wr_n),
    .i_data(din), .o_data(dout), .o_data_oe(oe), .o_bus_driver_disable(bus_driver_disable),
    .o_selected(sel), .o_sout(sout), .i_sin(sin), .i_rclk(baud),
    .o_baud_clock_out(baud), .o_rts_n(rts_n), .o_dtr_n(mo_n[0]), .o_out1_n(mo_n[1]),
    .o_out2_n(mo_n[2]),
    .i_cts_n(mdm_n), .i_dsr_n(mdm_n), .i_dcd_n(mdm_n), .i_ri_n(mdm_n),
    .o_interrupt_out(irq), .o_rx_fifo_full());
  serial_peer #(.BIT(16 * 112)) serial_peer_inst (.i_clk(clk), .i_sout(sout),
    .o_sin(sin), .o_mdm_n(mdm_n));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobe held for hold cycles; oe_seen records a driven read with the transceiver turned
  task automatic bus(input logic w, low, input logic [2:0] a, input logic [7:0] dv,
                     input int hold);
    oe_seen = 1'b0;
    @(negedge clk);
    rsel = a;
    din  = dv;
    if (w) {wr, wr_n} = {2{~low}};
    else {rd, rd_n} = {2{~low}};
    for (int i = 0; i < hold + 2; i++) begin
      @(negedge clk);
      if (oe === 1'b1 && bus_driver_disable === 1'b0) oe_seen = 1'b1;
      if (i == hold - 1) {rd, rd_n, wr, wr_n} = 4'h5;
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, mask, input logic low,
                     input int hold);
    bus(1'b0, low, a, 8'h00, hold);
    chk(dout & mask, exp);
    chk({7'h00, oe_seen}, 8'h01);
  endtask
  task automatic wrc(input logic [2:0] a, input logic [7:0] dv, input logic low);
    bus(1'b1, low, a, dv, 1);
  endtask

  initial begin
    {rsel, address_strobe, rd, wr, mrst, rst_n, din} = '0;
    {rd_n, wr_n} = 2'h3;
    cs = 3'h3;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // Let the combinational outputs settle before looking at them
    #1;
    chk({7'h00, bus_driver_disable}, 8'h01);
    chk({7'h00, inv_clk}, 8'h01);
    chk({6'h00, sout, rts_n}, 8'h03);
    chk({6'h00, sel, irq}, 8'h02);
    rdc(REG_LCTL, 8'h00, 8'hFF, 1'b1, 1);
    rdc(REG_LSTAT, 8'h60, 8'h7F, 1'b0, 1);
    rdc(REG_IID, 8'h01, 8'h0F, 1'b1, 1);
    wrc(REG_SCR, 8'hA5, 1'b0);
    rdc(REG_SCR, 8'hA5, 8'hFF, 1'b1, 1);
    cs = 3'h7;
    #1;
    chk({7'h00, sel}, 8'h00);
    wrc(REG_SCR, 8'h3C, 1'b1);
    bus(1'b0, 1'b0, REG_SCR, 8'h00, 1);
    chk({7'h00, oe_seen}, 8'h00);
    cs = 3'h1;
    #1;
    chk({7'h00, sel}, 8'h00);
    cs = 3'h3;
    rdc(REG_SCR, 8'hA5, 8'hFF, 1'b0, 1);
    rsel = REG_SCR;
    address_strobe  = 1'b1;
    rdc(REG_LCTL, 8'hA5, 8'hFF, 1'b0, 1);
    address_strobe = 1'b0;
    wrc(REG_MCTL, 8'h02, 1'b1);
    chk({4'h0, mo_n, rts_n}, 8'h0E);
    mrst = 1'b1;
    @(negedge clk);
    mrst = 1'b0;
    rdc(REG_MCTL, 8'h00, 8'hFF, 1'b0, 1);
    chk({7'h00, rts_n}, 8'h01);
    // Divisor below the floor must still give the fastest-allowed tick
    wrc(REG_LCTL, 8'h80, 1'b0);
    wrc(3'h0, 8'h05, 1'b0);
    wrc(3'h1, 8'h00, 1'b0);
    wrc(REG_LCTL, 8'h1A, 1'b0);
    n = 0;
    while (baud !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (baud !== 1'b1 && n < 300);
    chk(8'(n), 8'h70);
    wrc(REG_DATA, 8'h5B, 1'b1);
    serial_peer_inst.recv(7, 1'b1, d, p, ok);
    chk(d, 8'h5B);
    chk({7'h00, p}, {7'h00, ^(8'h5B & 8'h7F)});
    chk({7'h00, ok}, 8'h01);
    wrc(REG_LCTL, 8'h5A, 1'b0);
    chk({7'h00, sout}, 8'h00);
    wrc(REG_LCTL, 8'h0B, 1'b0);
    serial_peer_inst.send(8'hC5, 8, 1'b1, 1'b0, 1'b1);
    serial_peer_inst.send(8'h3A, 8, 1'b1, 1'b0, 1'b0);
    repeat (20) @(negedge clk);
    rdc(REG_LSTAT, 8'h09, 8'h09, 1'b0, 1);
    wrc(REG_IEN, 8'h01, 1'b0);
    wrc(REG_MCTL, 8'h08, 1'b0);
    chk({7'h00, irq}, 8'h01);
    rdc(REG_IID, 8'h04, 8'h0F, 1'b1, 1);
    rdc(REG_DATA, 8'hC5, 8'hFF, 1'b1, 3);
    rdc(REG_DATA, 8'h3A, 8'hFF, 1'b0, 1);
    rdc(REG_LSTAT, 8'h00, 8'h01, 1'b1, 1);
    chk({7'h00, irq}, 8'h00);
    // Loopback: pins go quiet and a short character comes back internally
    wrc(REG_MCTL, 8'h1A, 1'b0);
    chk({3'h0, sout, mo_n, rts_n}, 8'h1F);
    wrc(REG_LCTL, 8'h00, 1'b0);
    wrc(REG_DATA, 8'h15, 1'b1);
    repeat (14000) @(negedge clk);
    rdc(REG_LSTAT, 8'h01, 8'h1F, 1'b0, 1);
    rdc(REG_DATA, 8'h15, 8'hFF, 1'b1, 1);
    stop_test();
  end
endmodule
